/* File: rtl/arf_pkg.sv */
package arf_pkg;

  // ----------------------------------------
  // Register map (byte offsets, own choice)
  // ----------------------------------------
  localparam logic [2:0] ARF_ADDR_SEL    = 3'h0;
  localparam logic [2:0] ARF_ADDR_RES_LO = 3'h1;
  localparam logic [2:0] ARF_ADDR_RES_HI = 3'h2;
  localparam logic [2:0] ARF_ADDR_STAT   = 3'h3;

  localparam logic [7:0] ARF_SEL_RESET   = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ARF_REF_HI   = 7;
  localparam int ARF_REF_LO   = 6;
  localparam int ARF_ALIGN    = 5;
  localparam int ARF_CHAN_HI  = 4;
  localparam int ARF_STAT_DONE = 0;
  localparam int ARF_STAT_BUSY = 1;

  localparam int ARF_RES_W = 10;

  localparam logic [9:0] ARF_CODE_MIN_SE   = 10'h000;
  localparam logic [9:0] ARF_CODE_MAX_SE   = 10'h3ff;
  localparam logic [9:0] ARF_CODE_MIN_DIFF = 10'h200;
  localparam logic [9:0] ARF_CODE_MAX_DIFF = 10'h1ff;

  // ----------------------------------------
  // Reference select encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    ARF_REF_EXT_PIN  = 2'b00,
    ARF_REF_SUPPLY   = 2'b01,
    ARF_REF_RESERVED = 2'b10,
    ARF_REF_INT_256  = 2'b11
  } arf_ref_t;

  localparam logic [4:0] ARF_CH_SE_LAST = 5'h07;
  localparam logic [4:0] ARF_CH_BANDGAP = 5'h1e;
  localparam logic [4:0] ARF_CH_GROUND  = 5'h1f;

  // Settings applied to the analog core
  typedef struct packed {
    arf_ref_t   ref_sel;
    logic [4:0] chan;
  } arf_analog_cfg_t;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } arf_bus_req_t;

endpackage

/* File: rtl/arf_align.sv */
`timescale 1ns/1ps

module arf_align
  import arf_pkg::*;
(
  // Result in
  input  wire logic [9:0] result_i,
  input  wire logic       left_i,
  // Formatted bytes
  output logic      [7:0] low_o,
  output logic      [7:0] high_o
);

  always_comb begin
    if (left_i) begin
      high_o = result_i[9:2];
      low_o  = {result_i[1:0], 6'h00};
    end else begin
      low_o  = result_i[7:0];
      high_o = {6'h00, result_i[9:8]};
    end
  end

endmodule

/* File: rtl/arf_top.sv */
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

// Functional notes
// - Single-ended result is unsigned ten bits
// - Differential result in two's complement
// - Result MSB is sign for differential
// - Done flag high means result bytes valid
// - Reference change deferred until conversion done
// - Decode reference select to analog controls
// - Align bit chooses left or right adjust
// - Align change affects result bytes immediately
// - Channel field selects input and gain
// - Done flag set on completion, W1C clear
module arf_top
  import arf_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  // Register bus
  input  wire logic [2:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  // Analog core side
  input  wire logic            conv_busy_i,
  input  wire logic            conv_done_i,
  input  wire logic [9:0]      conv_code_i,
  input  wire logic            vector_ack_i,
  output arf_pkg::arf_analog_cfg_t cfg_o,
  output logic                 ext_ref_en_o,
  output logic                 supply_ref_en_o,
  output logic                 int_ref_en_o,
  output logic                 diff_mode_o,
  output logic                 result_sign_bit_o,
  output logic                 conversion_done_flag_o
);

  import arf_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]      sel_r,    sel_nxt;
  arf_analog_cfg_t cfg_r,    cfg_nxt;
  logic [9:0]      res_r,    res_nxt;
  logic            done_r,   done_nxt;
  logic [7:0]      rdata_r,  rdata_nxt;
  logic [7:0]      res_lo;
  logic [7:0]      res_hi;
  logic            sel_wr;

  assign sel_wr = wr_i && (addr_i == ARF_ADDR_SEL);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    sel_nxt  = sel_r;
    cfg_nxt  = cfg_r;
    res_nxt  = res_r;
    done_nxt = done_r;
    if (sel_wr) begin
      sel_nxt = wdata_i;
    end
    // Analog settings follow the register when no conversion runs or one completes,
    // so a mid-conversion write lands after its completion.
    if (!conv_busy_i || conv_done_i) begin
      cfg_nxt.ref_sel = arf_ref_t'(sel_nxt[ARF_REF_HI:ARF_REF_LO]);
      cfg_nxt.chan    = sel_nxt[ARF_CHAN_HI:0];
    end
    // Code is stored raw; unsigned or two's complement per channel kind
    if (conv_done_i) begin
      res_nxt = conv_code_i;
    end
    // Clear by write of one or vector ack; new completion wins
    if ((wr_i && addr_i == ARF_ADDR_STAT && wdata_i[ARF_STAT_DONE]) || vector_ack_i) begin
      done_nxt = 1'b0;
    end
    if (conv_done_i) begin
      done_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // Result formatting
  // ----------------------------------------
  arf_align u_align (
    .result_i (res_r),
    .left_i   (sel_r[ARF_ALIGN]),
    .low_o    (res_lo),
    .high_o   (res_hi)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_i) begin
      case (addr_i)
        ARF_ADDR_SEL:    rdata_nxt = sel_r;
        ARF_ADDR_RES_LO: rdata_nxt = res_lo;
        ARF_ADDR_RES_HI: rdata_nxt = res_hi;
        ARF_ADDR_STAT: begin
          rdata_nxt[ARF_STAT_DONE] = done_r;
          rdata_nxt[ARF_STAT_BUSY] = conv_busy_i;
        end
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r   <= ARF_SEL_RESET;
      cfg_r   <= '0;
      res_r   <= ARF_CODE_MIN_SE;
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      sel_r   <= sel_nxt;
      cfg_r   <= cfg_nxt;
      res_r   <= res_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o                = rdata_r;
  assign cfg_o                  = cfg_r;
  // Reserved code drives no reference at all
  assign ext_ref_en_o           = (cfg_r.ref_sel == ARF_REF_EXT_PIN);
  assign supply_ref_en_o        = (cfg_r.ref_sel == ARF_REF_SUPPLY);
  assign int_ref_en_o           = (cfg_r.ref_sel == ARF_REF_INT_256);
  assign diff_mode_o            = (cfg_r.chan > ARF_CH_SE_LAST) &&
                                  (cfg_r.chan < ARF_CH_BANDGAP);
  assign result_sign_bit_o      = res_r[ARF_RES_W-1];
  assign conversion_done_flag_o = done_r;

endmodule

/* File: tb/arf_top_sva.sv */
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module arf_top_sva
  import arf_pkg::*;
(
  // Clock, reset, bus
  input wire logic            ref_clk_i,
  input wire logic            rst_i,
  input wire logic            rd_i,
  input wire logic [7:0]      rdata_o,
  // Core side
  input wire logic            conv_busy_i,
  input wire logic            conv_done_i,
  input wire logic [9:0]      conv_code_i,
  input wire logic            vector_ack_i,
  input wire arf_analog_cfg_t cfg_o,
  input wire logic            ext_ref_en_o,
  input wire logic            supply_ref_en_o,
  input wire logic            int_ref_en_o,
  input wire logic            diff_mode_o,
  input wire logic            result_sign_bit_o,
  input wire logic            conversion_done_flag_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_flag_set: assert property (conv_done_i |=> conversion_done_flag_o)
    else $error("done flag not set");
  a_flag_clear: assert property (vector_ack_i && !conv_done_i |=> !conversion_done_flag_o)
    else $error("done flag not cleared");
  a_cfg_hold: assert property (conv_busy_i && !conv_done_i |=> $stable(cfg_o))
    else $error("setting changed mid conversion");
  a_ref_decode: assert property ({ext_ref_en_o, supply_ref_en_o, int_ref_en_o} ==
    {cfg_o.ref_sel == 2'b00, cfg_o.ref_sel == 2'b01, cfg_o.ref_sel == 2'b11})
    else $error("reference decode wrong");
  a_sign_take: assert property (conv_done_i |=> result_sign_bit_o == $past(conv_code_i[9]))
    else $error("sign bit not stored");
  a_sign_hold: assert property (!conv_done_i |=> $stable(result_sign_bit_o))
    else $error("result changed without completion");
  a_diff_range: assert property (diff_mode_o == (cfg_o.chan inside {[5'h08:5'h1d]}))
    else $error("channel mode decode wrong");
  a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  c_done: cover property (conv_done_i);
  c_busy_rd: cover property (conv_busy_i && rd_i);
  c_ack: cover property (vector_ack_i && conversion_done_flag_o);
endmodule

bind arf_top arf_top_sva sva_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .conv_busy_i(conv_busy_i), .conv_done_i(conv_done_i),
  .conv_code_i(conv_code_i), .vector_ack_i(vector_ack_i), .cfg_o(cfg_o),
  .ext_ref_en_o(ext_ref_en_o), .supply_ref_en_o(supply_ref_en_o),
  .int_ref_en_o(int_ref_en_o), .diff_mode_o(diff_mode_o),
  .result_sign_bit_o(result_sign_bit_o), .conversion_done_flag_o(conversion_done_flag_o));

/* File: tb/arf_core_model.sv */
`timescale 1ns/1ps
module arf_core_model (
  // Control from bench
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [9:0] code_i,
  input  wire logic [3:0] lat_i,
  // Core outputs
  output logic            busy_o = 1'b0,
  output logic            done_o = 1'b0,
  output logic      [9:0] code_o = 10'h000
);
  logic [3:0] cnt_r = 4'h0;
  // Code scrambles outside done, so a stale sample cannot pass
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    code_o <= ~code_o;
    cnt_r <= start_i ? lat_i : cnt_r - 4'h1;
    if (start_i) begin
      busy_o <= 1'b1;
    end else if (busy_o && cnt_r == 4'h0) begin
      busy_o <= 1'b0;
      done_o <= 1'b1;
      code_o <= code_i;
    end
  end
endmodule

/* File: tb/arf_top_test.sv */
`timescale 1ns/1ps
module arf_top_test;
  import arf_pkg::*;
  logic clk = 1'b0, rst = 1'b1, st = 1'b0, ack = 1'b0, busy, done;
  logic ext, sup, inr, diff, sign, flag;
  logic [9:0] code = 10'h000, cc;
  logic [3:0] lat = 4'h0;
  logic [7:0] rdata;
  arf_bus_req_t req = '0;
  arf_analog_cfg_t cfg;
  int fail_count = 0, total_checks = 0, cyc = 0;
  arf_top dut (.ref_clk_i(clk), .rst_i(rst), .addr_i(req.addr), .wdata_i(req.wdata),
    .wr_i(req.wr), .rd_i(req.rd), .rdata_o(rdata), .conv_busy_i(busy), .conv_done_i(done),
    .conv_code_i(cc), .vector_ack_i(ack), .cfg_o(cfg), .ext_ref_en_o(ext),
    .supply_ref_en_o(sup), .int_ref_en_o(inr), .diff_mode_o(diff),
    .result_sign_bit_o(sign), .conversion_done_flag_o(flag));
  arf_core_model core (.clk_i(clk), .start_i(st), .code_i(code), .lat_i(lat),
    .busy_o(busy), .done_o(done), .code_o(cc));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Start on one edge; with wt set, completion is polled for up to 30 negedges, else no wait
  task automatic conv(input logic [9:0] c, input logic [3:0] l, input bit wt);
    @(posedge clk);
    {st, code, lat} <= {1'b1, c, l};
    @(posedge clk);
    st <= 1'b0;
    for (int i = 0; wt && i < 30 && flag !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic t_format();
    rd(ARF_ADDR_SEL, ARF_SEL_RESET);
    wr(ARF_ADDR_SEL, 8'hed);
    conv(10'h270, 4'h2, 1);
    chk({sign, diff}, 2'b11);
    rd(ARF_ADDR_RES_LO, 8'h00);
    rd(ARF_ADDR_RES_HI, 8'h9c);
    wr(ARF_ADDR_SEL, 8'hcd);
    rd(ARF_ADDR_RES_LO, 8'h70);
    rd(ARF_ADDR_RES_HI, 8'h02);
    wr(ARF_ADDR_STAT, 8'h01);
    wr(ARF_ADDR_SEL, 8'h27);
    conv(10'h3ff, 4'h0, 1);
    rd(ARF_ADDR_RES_HI, 8'hff);
    rd(ARF_ADDR_STAT, 8'h01);
    wr(ARF_ADDR_STAT, 8'h01);
    rd(ARF_ADDR_STAT, 8'h00);
  endtask
  task automatic t_defer();
    conv(10'h029, 4'h8, 0);
    wr(ARF_ADDR_SEL, 8'hfb);
    @(negedge clk) chk(cfg, 10'h007);
    conv(10'h029, 4'h0, 1);
    chk({cfg, inr, sign}, {7'h7b, 2'b10});
    rd(ARF_ADDR_RES_LO, 8'h40);
    conv(10'h001, 4'h8, 0);
    wr(ARF_ADDR_SEL, 8'hdb);
    rd(ARF_ADDR_RES_LO, 8'h29);
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    @(negedge clk) chk(flag, 1'b0);
    rd(3'h5, 8'h00);
    for (int r = 0; r < 4; r++) begin
      wr(ARF_ADDR_SEL, 8'(r << 6));
      @(negedge clk) chk({ext, sup, inr}, {r == 0, r == 1, r == 3});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_format();
    t_defer();
    stop_test();
  end
endmodule
